// [include/dce_defs.svh]
// constants of the dac calibration engine: widths, reset values and factory defaults
`ifndef DCE_DEFS_SVH
`define DCE_DEFS_SVH

`define DCE_NCH 8
`define DCE_CH_W 3
`define DCE_CODE_W 12
`define DCE_GAIN_DEF 12'h800
`define DCE_ZERO_DEF 12'h000
`define DCE_INPUT_DEF 12'h000
`define DCE_CODE_MIN 12'h000
`define DCE_CODE_MID 12'h800
`define DCE_CODE_MAX 12'hfff
`define DCE_GAIN_BIAS 13'h0800
`define DCE_QUO_LSB 12
`define DCE_SHIFT_G6_DEF 12'h99a
`define DCE_SHIFT_G4_DEF 12'haab

`endif

// [include/dce_pkg.sv]
// types and format helper shared by the dac calibration engine files
`default_nettype none

package dce_pkg;

   // ==========================================================
   // register selectors of the write and read ports
   typedef enum logic [2:0] {
      DCE_SEL_INPUT = 3'h0,
      DCE_SEL_GAIN = 3'h1,
      DCE_SEL_ZERO = 3'h2,
      DCE_SEL_DATA = 3'h3,
      DCE_SEL_SHIFT_A = 3'h4,
      DCE_SEL_SHIFT_B = 3'h5
   } dce_sel_t;

   // ==========================================================
   // engine sequencer
   typedef enum logic [1:0] {
      DCE_ST_IDLE = 2'b00,
      DCE_ST_CALC = 2'b01
   } dce_state_t;

   // ==========================================================
   // twos complement and straight binary differ only in the msb
   function automatic logic [11:0] dce_fmt(input logic [11:0] v, input logic btc);
      return btc ? {~v[11], v[10:0]} : v;
   endfunction : dce_fmt

endpackage : dce_pkg

`default_nettype wire

// [logic/dce_corr.sv]
// one-cycle gain and zero correction datapath
`include "dce_defs.svh"
`default_nettype none

module dce_corr import dce_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   input wire logic [2:0] ch_in,
   input wire logic [11:0] raw_in,
   input wire logic [11:0] gain_in,
   input wire logic [11:0] zero_in,
   output logic done_out,
   output logic [2:0] ch_out,
   output logic [11:0] code_out
);

   // ==========================================================
   // arithmetic
   logic [24:0] prod;
   logic [12:0] quo;
   logic signed [14:0] sum;
   logic [11:0] sat_d;

   always_comb begin
      prod = 25'({12'h000, raw_in}) * 25'({1'b0, gain_in} + `DCE_GAIN_BIAS);
      quo = prod[24:`DCE_QUO_LSB];
      sum = signed'({2'b00, quo}) + signed'({{3{zero_in[11]}}, zero_in});
      if (sum < 15'sd0) begin
         sat_d = `DCE_CODE_MIN;
      end else if (sum > signed'({3'b000, `DCE_CODE_MAX})) begin
         sat_d = `DCE_CODE_MAX;
      end else begin
         sat_d = sum[11:0];
      end
   end

   // ==========================================================
   // result register
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_out <= 1'b0;
         ch_out <= 3'h0;
         code_out <= 12'h000;
      end else begin
         done_out <= start_in;
         if (start_in) begin
            ch_out <= ch_in;
            code_out <= sat_d;
         end
      end
   end

endmodule : dce_corr

`default_nettype wire

// [logic/dce_engine.sv]
// shared calibration engine of an octal 12-bit dac: trim registers, data registers, latches
`include "dce_defs.svh"
`default_nettype none

module dce_engine import dce_pkg::*; #(
   parameter int NCH = `DCE_NCH,
   // factory trims, one pair per group; values are plain nominal defaults
   parameter logic [11:0] SHIFT_A_G6 = `DCE_SHIFT_G6_DEF,
   parameter logic [11:0] SHIFT_A_G4 = `DCE_SHIFT_G4_DEF,
   parameter logic [11:0] SHIFT_B_G6 = `DCE_SHIFT_G6_DEF,
   parameter logic [11:0] SHIFT_B_G4 = `DCE_SHIFT_G4_DEF
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic wr_en_in,
   input wire dce_sel_t wr_sel_in,
   input wire logic [2:0] wr_ch_in,
   input wire logic [11:0] wr_data_in,
   input wire logic rd_en_in,
   input wire dce_sel_t rd_sel_in,
   input wire logic [2:0] rd_ch_in,
   input wire logic correction_enable_in,
   input wire logic amp_gain6_in,
   input wire logic format_select_pin_in,
   input wire logic dual_supply_in,
   input wire logic reset_value_select_in,
   input wire logic latch_load_pin_in,
   input wire logic latch_load_bit_in,
   output logic [11:0] rd_data_out,
   output logic rd_valid_out,
   output logic [NCH*12-1:0] dac_latch_out,
   output logic [11:0] shift_dac_code_a_out,
   output logic [11:0] shift_dac_code_b_out,
   output logic shift_dac_pd_out,
   output logic amp_gain6_out,
   output logic engine_busy_out
);

   // ==========================================================
   // elaboration check
   // two groups of four channels and a 3-bit channel index are built in
   if (NCH != `DCE_NCH) begin : g_bad_nch
      $error("dce_engine supports exactly eight channels");
   end
   if (`DCE_CODE_W != 12) begin : g_bad_w
      $error("dce_engine datapath is built for 12-bit codes");
   end

   // ==========================================================
   // storage
   logic [11:0] input_q [NCH];
   logic [11:0] gain_q [NCH];
   logic [11:0] zero_q [NCH];
   logic [11:0] data_q [NCH];
   logic [NCH-1:0][11:0] latch_q;
   logic [11:0] shift_a_q;
   logic [11:0] shift_b_q;

   logic init_q;
   logic async_q;
   logic ldpin_q;
   logic gain_prev_q;
   logic load_req_q;
   logic load_req_d;
   dce_state_t state_q;
   dce_state_t state_d;
   logic [NCH-1:0] pend_q;
   logic [NCH-1:0] pend_d;
   logic [NCH-1:0] pend_set;
   logic [NCH-1:0] pend_clr;
   logic [2:0] pick_ch;
   logic start;
   logic wr_ok;
   logic direct_wr;
   logic load_new;
   logic load_serve;
   logic gain_changed;
   logic corr_done;
   logic [2:0] corr_ch;
   logic [11:0] corr_code;
   logic [11:0] rd_d;
   logic busy_q;
   logic rd_valid_q;
   logic [11:0] rd_data_q;
   logic pd_q;
   logic gain6_q;

   // the first cycle after reset catches the straps; host access waits for it
   assign wr_ok = wr_en_in && !init_q;
   assign direct_wr = wr_ok && !correction_enable_in && (wr_sel_in == DCE_SEL_INPUT);
   assign gain_changed = !init_q && (amp_gain6_in != gain_prev_q);

   // ==========================================================
   // strap capture and edge history
   // the update mode is frozen at power-up; later falling edges of the load pin only request loads, and only in sync mode
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         init_q <= 1'b1;
         async_q <= 1'b0;
         ldpin_q <= 1'b1;
         gain_prev_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
         ldpin_q <= latch_load_pin_in;
         gain_prev_q <= amp_gain6_in;
         if (init_q) begin
            // load pin low at power-up fixes the asynchronous update mode
            async_q <= !latch_load_pin_in;
         end
      end
   end

   // ==========================================================
   // pending channels and sequencer
   always_comb begin
      pend_set = '0;
      pend_clr = '0;
      pick_ch = 3'h0;
      if (wr_ok && correction_enable_in && (wr_sel_in == DCE_SEL_INPUT || wr_sel_in == DCE_SEL_GAIN ||
          wr_sel_in == DCE_SEL_ZERO)) begin
         pend_set[wr_ch_in] = 1'b1;
      end
      // lowest pending index wins; one channel rewritten without pause starves the higher ones
      for (int i = NCH - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            pick_ch = 3'(i);
         end
      end
      start = (state_q == DCE_ST_IDLE) && (pend_q != '0);
      if (start) begin
         pend_clr[pick_ch] = 1'b1;
      end
      // a write landing as its channel is taken re-arms it: set wins
      pend_d = (pend_q & ~pend_clr) | pend_set;
      case (state_q)
         DCE_ST_IDLE: begin
            state_d = start ? DCE_ST_CALC : DCE_ST_IDLE;
         end
         DCE_ST_CALC: begin
            state_d = corr_done ? DCE_ST_IDLE : DCE_ST_CALC;
         end
         default: begin
            state_d = DCE_ST_IDLE;
         end
      endcase
   end

   // busy comes from the next-state terms so it rises at the edge that takes the write
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= DCE_ST_IDLE;
         pend_q <= '0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q <= pend_d;
         busy_q <= (pend_d != '0) || (state_d != DCE_ST_IDLE);
      end
   end

   // the single shared datapath
   dce_corr u_corr (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .start_in(start),
      .ch_in(pick_ch),
      .raw_in(input_q[pick_ch]),
      .gain_in(gain_q[pick_ch]),
      .zero_in(zero_q[pick_ch]),
      .done_out(corr_done),
      .ch_out(corr_ch),
      .code_out(corr_code)
   );

   // ==========================================================
   // input and trim registers
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < NCH; i++) begin
            input_q[i] <= `DCE_INPUT_DEF;
            gain_q[i] <= `DCE_GAIN_DEF;
            zero_q[i] <= `DCE_ZERO_DEF;
         end
      end else if (wr_ok) begin
         case (wr_sel_in)
            DCE_SEL_INPUT: begin
               input_q[wr_ch_in] <= dce_fmt(wr_data_in, format_select_pin_in);
            end
            DCE_SEL_GAIN: begin
               gain_q[wr_ch_in] <= wr_data_in;
            end
            DCE_SEL_ZERO: begin
               zero_q[wr_ch_in] <= wr_data_in;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // synchronous load requests
   assign load_new = !init_q && !async_q && (latch_load_bit_in || (ldpin_q && !latch_load_pin_in));
   // hold the load until the engine has drained every pending channel
   assign load_serve = load_req_q && (pend_q == '0) && (state_q == DCE_ST_IDLE) && !direct_wr;
   assign load_req_d = (load_req_q && !load_serve) || load_new;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         load_req_q <= 1'b0;
      end else begin
         load_req_q <= load_req_d;
      end
   end

   // ==========================================================
   // dac data registers and latches
   // in sync mode the data registers fill quietly and the latches wait for a served load
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < NCH; i++) begin
            data_q[i] <= `DCE_CODE_MIN;
            latch_q[i] <= `DCE_CODE_MIN;
         end
      end else if (init_q) begin
         // reset value is held in straight binary, so the format pin plays no part here
         for (int i = 0; i < NCH; i++) begin
            data_q[i] <= reset_value_select_in ? `DCE_CODE_MID : `DCE_CODE_MIN;
            latch_q[i] <= reset_value_select_in ? `DCE_CODE_MID : `DCE_CODE_MIN;
         end
      end else begin
         if (load_serve) begin
            for (int i = 0; i < NCH; i++) begin
               latch_q[i] <= data_q[i];
            end
         end
         if (corr_done && state_q == DCE_ST_CALC) begin
            data_q[corr_ch] <= corr_code;
            if (async_q) begin
               latch_q[corr_ch] <= corr_code;
            end
         end
         // a direct write is newer than any result still in flight
         if (direct_wr) begin
            data_q[wr_ch_in] <= dce_fmt(wr_data_in, format_select_pin_in);
            if (async_q) begin
               latch_q[wr_ch_in] <= dce_fmt(wr_data_in, format_select_pin_in);
            end
         end
      end
   end

   // ==========================================================
   // shift dac code registers
   // a gain change reloads the factory code and drops a shift write of the same cycle
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift_a_q <= `DCE_CODE_MIN;
         shift_b_q <= `DCE_CODE_MIN;
      end else if (init_q || gain_changed) begin
         shift_a_q <= amp_gain6_in ? SHIFT_A_G6 : SHIFT_A_G4;
         shift_b_q <= amp_gain6_in ? SHIFT_B_G6 : SHIFT_B_G4;
      end else if (wr_ok && wr_sel_in == DCE_SEL_SHIFT_A) begin
         shift_a_q <= dce_fmt(wr_data_in, format_select_pin_in);
      end else if (wr_ok && wr_sel_in == DCE_SEL_SHIFT_B) begin
         shift_b_q <= dce_fmt(wr_data_in, format_select_pin_in);
      end
   end

   // ==========================================================
   // read-back
   // codes are stored in straight binary and turned back to the pin's format here
   always_comb begin
      case (rd_sel_in)
         DCE_SEL_INPUT: rd_d = dce_fmt(input_q[rd_ch_in], format_select_pin_in);
         DCE_SEL_GAIN: rd_d = gain_q[rd_ch_in];
         DCE_SEL_ZERO: rd_d = zero_q[rd_ch_in];
         DCE_SEL_DATA: rd_d = dce_fmt(data_q[rd_ch_in], format_select_pin_in);
         DCE_SEL_SHIFT_A: rd_d = dce_fmt(shift_a_q, format_select_pin_in);
         DCE_SEL_SHIFT_B: rd_d = dce_fmt(shift_b_q, format_select_pin_in);
         default: rd_d = 12'h000;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 12'h000;
      end else begin
         rd_valid_q <= rd_en_in && !init_q;
         if (rd_en_in && !init_q) begin
            rd_data_q <= rd_d;
         end
      end
   end

   // ==========================================================
   // analog configuration outputs
   // single supply only powers the shift dacs down; their codes stay for a later return
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pd_q <= 1'b1;
         gain6_q <= 1'b1;
      end else begin
         pd_q <= !dual_supply_in;
         gain6_q <= amp_gain6_in;
      end
   end

   assign rd_data_out = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign dac_latch_out = latch_q;
   assign shift_dac_code_a_out = shift_a_q;
   assign shift_dac_code_b_out = shift_b_q;
   assign shift_dac_pd_out = pd_q;
   assign amp_gain6_out = gain6_q;
   assign engine_busy_out = busy_q;

endmodule : dce_engine

`default_nettype wire

// [verification/dce_engine_properties.sv]
// port timing checker of the dac calibration engine
`include "dce_defs.svh"
`default_nettype none

module dce_engine_properties import dce_pkg::*; #(
   parameter int NCH = `DCE_NCH,
   parameter logic [11:0] SHIFT_A_G6 = `DCE_SHIFT_G6_DEF,
   parameter logic [11:0] SHIFT_A_G4 = `DCE_SHIFT_G4_DEF
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic wr_en_in,
   input wire dce_sel_t wr_sel_in,
   input wire logic [2:0] wr_ch_in,
   input wire logic [11:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic correction_enable_in,
   input wire logic amp_gain6_in,
   input wire logic format_select_pin_in,
   input wire logic dual_supply_in,
   input wire logic latch_load_pin_in,
   input wire logic rd_valid_out,
   input wire logic [NCH*12-1:0] dac_latch_out,
   input wire logic [11:0] shift_dac_code_a_out,
   input wire logic shift_dac_pd_out,
   input wire logic amp_gain6_out,
   input wire logic engine_busy_out
);
   // ====
   // helper state
   logic up_q;
   logic async_q;

   // the first edge after release only samples the straps
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         up_q <= 1'b0;
      end else begin
         up_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         async_q <= 1'b0;
      end else if (!up_q) begin
         async_q <= !latch_load_pin_in;
      end
   end

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   // ====
   // assertions
   read_answer_a: assert property (rd_valid_out == $past(rd_en_in && up_q))
      else $error("read answer not one cycle after request");
   direct_store_a: assert property (up_q && async_q && !correction_enable_in && wr_en_in &&
      wr_sel_in == DCE_SEL_INPUT |=> dac_latch_out[$past(wr_ch_in)*12 +: 12] ==
      $past(wr_data_in ^ {format_select_pin_in, 11'h000}))
      else $error("direct input write not in latch");
   busy_start_a: assert property (up_q && correction_enable_in && wr_en_in &&
      wr_sel_in inside {DCE_SEL_INPUT, DCE_SEL_GAIN, DCE_SEL_ZERO} |-> ##[1:2] engine_busy_out)
      else $error("write did not start a correction");
   no_calc_a: assert property (up_q && !correction_enable_in && !engine_busy_out |=> !engine_busy_out)
      else $error("engine started while correction off");
   busy_bound_a: assert property (engine_busy_out |-> ##[1:40] !engine_busy_out)
      else $error("engine busy too long");
   shift_pd_a: assert property (up_q |-> shift_dac_pd_out == $past(!dual_supply_in))
      else $error("shift dac power down wrong");
   amp_gain_a: assert property (up_q |-> amp_gain6_out == $past(amp_gain6_in))
      else $error("amplifier gain not applied");
   gain_reload_a: assert property (up_q && $changed(amp_gain6_in) |=>
      shift_dac_code_a_out == ($past(amp_gain6_in) ? SHIFT_A_G6 : SHIFT_A_G4))
      else $error("shift code not reloaded on gain change");
   shift_init_a: assert property (!up_q |=>
      shift_dac_code_a_out == ($past(amp_gain6_in) ? SHIFT_A_G6 : SHIFT_A_G4))
      else $error("shift code default wrong after reset");
endmodule : dce_engine_properties

bind dce_engine dce_engine_properties #(.NCH(NCH), .SHIFT_A_G6(SHIFT_A_G6), .SHIFT_A_G4(SHIFT_A_G4))
   u_dce_engine_properties (.ref_clk_in, .arst_n_in, .wr_en_in, .wr_sel_in, .wr_ch_in, .wr_data_in,
   .rd_en_in, .correction_enable_in, .amp_gain6_in, .format_select_pin_in, .dual_supply_in,
   .latch_load_pin_in, .rd_valid_out, .dac_latch_out, .shift_dac_code_a_out, .shift_dac_pd_out,
   .amp_gain6_out, .engine_busy_out);

`default_nettype wire

// [verification/dce_engine_tb.sv]
// self-checking bench of the dac calibration engine
`include "dce_defs.svh"
`default_nettype none

module dce_engine_tb import dce_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;

   // ====
   // signals
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic wr_en_in, rd_en_in, rd_valid_out, shift_dac_pd_out, amp_gain6_out, engine_busy_out;
   dce_sel_t wr_sel_in, rd_sel_in;
   logic [2:0] wr_ch_in, rd_ch_in;
   logic [11:0] wr_data_in, rd_data_out, shift_dac_code_a_out, shift_dac_code_b_out, d;
   logic [95:0] dac_latch_out;
   logic correction_enable_in = 1'b0;
   logic amp_gain6_in = 1'b1;
   logic format_select_pin_in = 1'b0;
   logic dual_supply_in = 1'b1;
   logic reset_value_select_in = 1'b0;
   logic latch_load_pin_in = 1'b0;
   logic latch_load_bit_in = 1'b0;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   // written input (twos complement), gain and zero trims per case
   logic [11:0] tin [4] = '{12'h7ff, 12'h7ff, 12'h900, 12'h2bc};
   logic [11:0] tg [4] = '{12'hfff, 12'h000, 12'h800, 12'h400};
   logic [11:0] tz [4] = '{12'h7ff, 12'h000, 12'h800, 12'h005};

   always #10 ref_clk_in = ~ref_clk_in;

   dce_engine u_dce_engine (.ref_clk_in, .arst_n_in, .wr_en_in, .wr_sel_in, .wr_ch_in, .wr_data_in,
      .rd_en_in, .rd_sel_in, .rd_ch_in, .correction_enable_in, .amp_gain6_in, .format_select_pin_in,
      .dual_supply_in, .reset_value_select_in, .latch_load_pin_in, .latch_load_bit_in, .rd_data_out,
      .rd_valid_out, .dac_latch_out, .shift_dac_code_a_out, .shift_dac_code_b_out, .shift_dac_pd_out,
      .amp_gain6_out, .engine_busy_out);

   dce_host u_dce_host (.ref_clk_in, .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
      .wr_sel_out(wr_sel_in), .wr_ch_out(wr_ch_in), .wr_data_out(wr_data_in), .rd_en_out(rd_en_in),
      .rd_sel_out(rd_sel_in), .rd_ch_out(rd_ch_in));

   // ====
   // helpers
   task automatic finish_test;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick

   // bounded wait for the engine to drain
   task automatic wait_idle;
      int n = 0;
      tick(2);
      while (engine_busy_out !== 1'b0 && n < 60) begin
         tick(1);
         n++;
      end
      if (n == 60) errors++;
      tick(1);
   endtask : wait_idle

   function automatic logic [11:0] lat(input int ch);
      return dac_latch_out[ch*12 +: 12];
   endfunction : lat

   function automatic logic [11:0] cexp(input logic [11:0] raw, input logic [11:0] g, input logic [11:0] z);
      int v;
      v = (int'(raw) * (int'(g) + 2048)) / 4096 + int'($signed(z));
      return (v < 0) ? 12'h000 : ((v > 4095) ? 12'hfff : v[11:0]);
   endfunction : cexp

   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         finish_test();
      end
   end

   // ====
   // tests
   initial begin
      tick(20);
      arst_n_in = 1'b1;
      tick(2);
      for (int i = 0; i < 8; i++) chk(lat(i), 12'h000);
      chk(shift_dac_code_b_out, `DCE_SHIFT_G6_DEF);
      u_dce_host.rd(DCE_SEL_GAIN, 3'h7, d);
      chk(d, 12'h800);
      u_dce_host.rd(DCE_SEL_ZERO, 3'h3, d);
      chk(d, 12'h000);
      u_dce_host.rd(DCE_SEL_INPUT, 3'h5, d);
      chk(d, 12'h000);
      u_dce_host.wr(DCE_SEL_GAIN, 3'h1, 12'h123);
      chk({11'h0, engine_busy_out}, 12'h000);
      tick(2);
      chk({11'h0, engine_busy_out}, 12'h000);
      u_dce_host.wr(DCE_SEL_INPUT, 3'h1, 12'h5a5);
      tick(1);
      chk(lat(1), 12'h5a5);
      format_select_pin_in = 1'b1;
      for (int i = 0; i < 3; i++) begin
         u_dce_host.wr(DCE_SEL_INPUT, 3'h2, tin[i+1] ^ 12'h100);
         tick(1);
         chk(lat(2), tin[i+1] ^ 12'h900);
      end
      u_dce_host.rd(DCE_SEL_INPUT, 3'h2, d);
      chk(d, tin[3] ^ 12'h100);
      correction_enable_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_dce_host.wr(DCE_SEL_GAIN, i[2:0], tg[i]);
         u_dce_host.wr(DCE_SEL_ZERO, i[2:0], tz[i]);
         u_dce_host.wr(DCE_SEL_INPUT, i[2:0], tin[i]);
      end
      wait_idle();
      for (int i = 0; i < 4; i++) chk(lat(i), cexp(tin[i] ^ 12'h800, tg[i], tz[i]));
      u_dce_host.rd(DCE_SEL_ZERO, 3'h2, d);
      chk(d, 12'h800);
      u_dce_host.rd(DCE_SEL_GAIN, 3'h1, d);
      chk(d, 12'h000);
      u_dce_host.wr(DCE_SEL_ZERO, 3'h3, 12'hffe);
      wait_idle();
      chk(lat(3), cexp(tin[3] ^ 12'h800, tg[3], 12'hffe));
      amp_gain6_in = 1'b0;
      tick(2);
      chk(shift_dac_code_b_out, `DCE_SHIFT_G4_DEF);
      chk({11'h0, amp_gain6_out}, 12'h000);
      u_dce_host.wr(DCE_SEL_SHIFT_A, 3'h0, 12'h123);
      tick(1);
      chk(shift_dac_code_a_out, 12'h923);
      chk(shift_dac_code_b_out, `DCE_SHIFT_G4_DEF);
      u_dce_host.rd(DCE_SEL_SHIFT_A, 3'h0, d);
      chk(d, 12'h123);
      u_dce_host.wr(DCE_SEL_SHIFT_B, 3'h0, 12'h456);
      tick(1);
      chk(shift_dac_code_b_out, 12'hc56);
      chk(shift_dac_code_a_out, 12'h923);
      dual_supply_in = 1'b0;
      tick(2);
      chk({11'h0, shift_dac_pd_out}, 12'h001);
      arst_n_in = 1'b0;
      latch_load_pin_in = 1'b1;
      reset_value_select_in = 1'b1;
      tick(3);
      arst_n_in = 1'b1;
      tick(2);
      chk(lat(6), 12'h800);
      u_dce_host.wr(DCE_SEL_INPUT, 3'h6, 12'h400);
      wait_idle();
      chk(lat(6), 12'h800);
      u_dce_host.wr(DCE_SEL_INPUT, 3'h6, 12'h100);
      latch_load_bit_in = 1'b1;
      tick(1);
      latch_load_bit_in = 1'b0;
      chk(lat(6), 12'h800);
      wait_idle();
      tick(2);
      chk(lat(6), 12'h900);
      chk(lat(5), 12'h800);
      u_dce_host.wr(DCE_SEL_INPUT, 3'h5, 12'h0aa);
      wait_idle();
      chk(lat(5), 12'h800);
      latch_load_pin_in = 1'b0;
      tick(1);
      latch_load_pin_in = 1'b1;
      tick(2);
      chk(lat(5), 12'h8aa);
      u_dce_host.rd(DCE_SEL_DATA, 3'h6, d);
      chk(d, 12'h100);
      finish_test();
   end
endmodule : dce_engine_tb

`default_nettype wire

// [verification/dce_host.sv]
// host model driving the write and read strobes of the engine
`default_nettype none

module dce_host import dce_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic [11:0] rd_data_in,
   output logic wr_en_out,
   output dce_sel_t wr_sel_out,
   output logic [2:0] wr_ch_out,
   output logic [11:0] wr_data_out,
   output logic rd_en_out,
   output dce_sel_t rd_sel_out,
   output logic [2:0] rd_ch_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      wr_en_out = 1'b0;
      wr_sel_out = DCE_SEL_INPUT;
      wr_ch_out = 3'h0;
      wr_data_out = 12'h000;
      rd_en_out = 1'b0;
      rd_sel_out = DCE_SEL_INPUT;
      rd_ch_out = 3'h0;
   end

   // released channel and data lines show the inverse so stale data cannot pass; the select lines keep their value
   task automatic wr(input dce_sel_t sel, input logic [2:0] ch, input logic [11:0] d);
      @(posedge ref_clk_in);
      #1;
      wr_sel_out = sel;
      wr_ch_out = ch;
      wr_data_out = d;
      wr_en_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      wr_en_out = 1'b0;
      wr_data_out = ~d;
      wr_ch_out = ~ch;
   endtask : wr

   task automatic rd(input dce_sel_t sel, input logic [2:0] ch, output logic [11:0] d);
      @(posedge ref_clk_in);
      #1;
      rd_sel_out = sel;
      rd_ch_out = ch;
      rd_en_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      rd_en_out = 1'b0;
      rd_ch_out = ~ch;
      @(posedge ref_clk_in);
      d = rd_data_in;
   endtask : rd
endmodule : dce_host

`default_nettype wire
